// ===== inc/ebh_pkg.sv
package ebh_pkg;
  // reset values of the pin side
  localparam logic RST_GRANT_N = 1'b1;
  localparam logic RST_HANG_N = 1'b1;
  localparam logic RST_DRV_EN = 1'b0;
  localparam logic [2:0] RST_MODE = 3'h0;
  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    EBH_OWN,
    EBH_WAIT_DONE,
    EBH_GRANTED
  } ebh_state_t;
endpackage : ebh_pkg

// ===== verif/ebh_chk.sv
`timescale 1ns/100ps
module ebh_chk
  import ebh_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bus_request_n,
  input wire logic emulator_enable,
  input wire logic go_mode,
  input wire logic core_ext_req,
  input wire logic ext_access_busy,
  input wire logic ext_access_done,
  input wire logic [2:0] mode_pins,
  input wire logic bus_grant_n,
  input wire logic bus_grant_oe,
  input wire logic emulator_bus_grant_n,
  input wire logic grant_hang_n,
  input wire logic mem_drive_en,
  input wire logic core_run,
  input wire logic ext_access_allow,
  input wire logic chip_reset,
  input wire logic [2:0] mem_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_idle; $fell(bus_request_n) ##0 (!bus_request_n
    && !ext_access_busy && !emulator_enable)[*6] |-> !bus_grant_n; endproperty
  a_idle: assert property (p_idle) else $error("no grant");
  property p_float; !bus_grant_n |-> !mem_drive_en && !ext_access_allow;
  endproperty
  a_float: assert property (p_float) else $error("drives");
  property p_busy; ext_access_busy && !ext_access_done |=> !$fell(bus_grant_n);
  endproperty
  a_busy: assert property (p_busy) else $error("early grant");
  property p_rel; $rose(bus_request_n) ##0 (bus_request_n && !emulator_enable)
    [*6] |-> bus_grant_n && grant_hang_n && mem_drive_en; endproperty
  a_rel: assert property (p_rel) else $error("no release");
  // under emulation the grant shows on the emulator pin instead
  property p_hang; !grant_hang_n |-> !bus_grant_n || !emulator_bus_grant_n;
  endproperty
  a_hang: assert property (p_hang) else $error("hang");
  property p_emu; emulator_enable[*6] |-> !bus_grant_oe; endproperty
  a_emu: assert property (p_emu) else $error("grant driven");
  property p_mode; (chip_reset && $stable(mode_pins))[*4]
    |-> mem_mode == mode_pins; endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_go; go_mode && !bus_grant_n && !core_ext_req |-> core_run;
  endproperty
  a_go: assert property (p_go) else $error("go halted");
  c_grant: cover property ($fell(bus_grant_n));
  c_go: cover property (go_mode && !bus_grant_n && core_run);
  c_emu: cover property (!bus_grant_oe);
endmodule : ebh_chk
bind ebh_top ebh_chk chk_u (.*);

// ===== verif/ebh_master_model.sv
`timescale 1ns/100ps
module ebh_master_model
(
  input wire logic clk,
  input wire logic want,
  input wire logic bus_grant_n,
  output logic bus_request_n,
  output logic owns_bus
);
  initial bus_request_n = 1'h1;
  // held for as long as the bus is needed
  always @(posedge clk) bus_request_n <= !want;
  // request alone never gives ownership
  assign owns_bus = want && !bus_grant_n;
endmodule : ebh_master_model

// ===== verif/tb.sv
`timescale 1ns/100ps
module tb
  import ebh_pkg::*;
();
  logic clk, reset_n, chip_reset_in_n, emulator_enable, emulator_reset_n;
  logic emulator_bus_request_n, emu_single_step, emu_halted, go_mode;
  logic core_ready, core_ext_req, ext_access_busy, ext_access_done, want;
  logic bus_request_n, bus_grant_n, bus_grant_oe, emulator_bus_grant_n;
  logic grant_hang_n, mem_drive_en, core_run, ext_access_allow, chip_reset;
  logic owns_bus;
  logic [2:0] mode_pins, mem_mode;
  int errors, check_count, cyc;
  ebh_top dut_u (.*);
  ebh_master_model mdl_u (.*);
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      results();
    end
  end
  task automatic chk(logic [2:0] got, logic [2:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %b not %b", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  task automatic wt(int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic t_idle();
    want = 1'h1;
    wt(8);
    chk(bus_grant_n, 1'h0);
    chk(mem_drive_en, 1'h0);
    chk(core_run, 1'h0);
    chk(grant_hang_n, 1'h0);
    chk(owns_bus, 1'h1);
    want = 1'h0;
    wt(8);
    chk(bus_grant_n, 1'h1);
    chk(grant_hang_n, 1'h1);
    chk(mem_drive_en, 1'h1);
  endtask : t_idle
  task automatic t_busy();
    ext_access_busy = 1'h1;
    core_ext_req = 1'h1;
    want = 1'h1;
    wt(8);
    chk(bus_grant_n, 1'h1);
    ext_access_done = 1'h1;
    wt(1);
    {ext_access_busy, ext_access_done} = 2'h0;
    wt(3);
    chk(bus_grant_n, 1'h0);
    chk(ext_access_allow, 1'h0);
    want = 1'h0;
    wt(8);
    chk(ext_access_allow, 1'h1);
    core_ext_req = 1'h0;
  endtask : t_busy
  task automatic t_go();
    go_mode = 1'h1;
    want = 1'h1;
    wt(8);
    chk(core_run, 1'h1);
    chk(grant_hang_n, 1'h1);
    core_ext_req = 1'h1;
    wt(2);
    chk(core_run, 1'h0);
    chk(grant_hang_n, 1'h0);
    {want, go_mode, core_ext_req} = 3'h0;
    wt(8);
  endtask : t_go
  task automatic t_rst();
    mode_pins = 3'h5;
    chip_reset_in_n = 1'h0;
    want = 1'h1;
    wt(8);
    chk(chip_reset, 1'h1);
    chk(bus_grant_n, 1'h0);
    chk(mem_mode, 3'h5);
    {want, chip_reset_in_n} = 2'h1;
    wt(8);
  endtask : t_rst
  task automatic t_emu();
    emulator_enable = 1'h1;
    emulator_bus_request_n = 1'h0;
    wt(8);
    chk(bus_grant_oe, 1'h0);
    chk(emulator_bus_grant_n, 1'h0);
    emu_single_step = 1'h1;
    {emulator_bus_request_n, emulator_reset_n} = 2'h2;
    wt(8);
    chk(emulator_bus_grant_n, 1'h0);
    chk(chip_reset, 1'h0);
    emu_single_step = 1'h0;
    mode_pins = 3'h2;
    wt(8);
    chk(emulator_bus_grant_n, 1'h1);
    chk(mem_mode, 3'h2);
    {emulator_reset_n, emulator_enable} = 2'h2;
    wt(8);
  endtask : t_emu
  initial
  begin
    {reset_n, emulator_enable, emu_single_step, emu_halted, go_mode} = '0;
    {core_ext_req, ext_access_busy, ext_access_done, want} = '0;
    {chip_reset_in_n, emulator_reset_n, emulator_bus_request_n} = '1;
    core_ready = 1'h1;
    mode_pins = 3'h0;
    wt(12);
    reset_n = 1'h1;
    wt(4);
    t_idle();
    t_busy();
    t_go();
    t_rst();
    t_emu();
    results();
  end
endmodule : tb

// ===== verilog/ebh_mode_latch.sv
`timescale 1ns/100ps
module ebh_mode_latch
  import ebh_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_reset,
  input wire logic [2:0] mode_pins,
  output logic [2:0] mode
);
  logic [2:0] mode_ff;
  logic [2:0] mode_s1_ff;
  logic [2:0] mode_s2_ff;
  // straps sampled through two stages, then captured while chip reset holds
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_s1_ff <= RST_MODE;
      mode_s2_ff <= RST_MODE;
    end
    else
    begin
      mode_s1_ff <= mode_pins;
      mode_s2_ff <= mode_s1_ff;
    end
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mode_ff <= RST_MODE;
    else if (chip_reset)
      mode_ff <= mode_s2_ff; // [RULE12]
  end
  assign mode = mode_ff;
endmodule : ebh_mode_latch

// ===== verilog/ebh_sync.sv
`timescale 1ns/100ps
module ebh_sync
  import ebh_pkg::*;
#(
  parameter logic INIT = 1'b1
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);
  logic stage1_ff;
  logic stage2_ff;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_ff <= INIT;
      stage2_ff <= INIT;
    end
    else
    begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
    end
  end
  assign dout = stage2_ff;
endmodule : ebh_sync

// ===== verilog/ebh_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] master holds request low while needing bus
// [RULE2] idle: grant next cycle, float, halt (code: grant_ff rises on the fourth clock edge after the request pin goes low)
// [RULE3] go mode: run until external access needed
// [RULE4] busy access: grant cycle after it completes
// [RULE5] grant allowed between two accesses
// [RULE6] request gone: drop grant, drive, resume
// [RULE7] requests honoured during boot and reset
// [RULE8] hang low when ready but bus granted
// [RULE9] release: drop grant, hang, then access (code: grant, hang and ext_access_allow all change on the same clock edge)
// [RULE10] emulator enable selects emulator pins
// [RULE11] normal grant floats under emulation
// [RULE12] emulator chip reset relatches memory mode
// [RULE13] emulation ignores reset, request when stepping
// [RULE14] master drives bus only while granted
// [RULE15] request synchronised before grant decision
module ebh_top
  import ebh_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_reset_in_n,
  input wire logic bus_request_n,
  input wire logic emulator_enable,
  input wire logic emulator_reset_n,
  input wire logic emulator_bus_request_n,
  input wire logic emu_single_step,
  input wire logic emu_halted,
  input wire logic go_mode,
  input wire logic [2:0] mode_pins,
  input wire logic core_ready,
  input wire logic core_ext_req,
  input wire logic ext_access_busy,
  input wire logic ext_access_done,
  output logic bus_grant_n,
  output logic bus_grant_oe,
  output logic emulator_bus_grant_n,
  output logic grant_hang_n,
  output logic mem_drive_en,
  output logic core_run,
  output logic ext_access_allow,
  output logic chip_reset,
  output logic [2:0] mem_mode
);
  logic req_pin_s;
  logic req_emu_s;
  logic rst_pin_s;
  logic rst_emu_s;
  logic ee_s;
  logic ignore_s;
  logic step_s;
  logic halt_s;
  logic req_ff;
  logic nxt_req;
  logic rst_ff;
  logic nxt_rst;
  ebh_state_t state_ff;
  ebh_state_t nxt_state;
  logic grant_ff;
  logic hang_ff;
  logic drv_ff;
  logic nxt_hang;

  function automatic logic pick(input logic sel, input logic a,
                                input logic b);
    pick = sel ? a : b;
  endfunction : pick

  // pins from outside pass two stages first
  ebh_sync #(.INIT(1'b1)) u_req_pin (
    .clk(clk), .reset_n(reset_n), .din(bus_request_n), .dout(req_pin_s)
  ); // [RULE15]
  ebh_sync #(.INIT(1'b1)) u_req_emu (
    .clk(clk), .reset_n(reset_n), .din(emulator_bus_request_n),
    .dout(req_emu_s)
  ); // [RULE15]
  ebh_sync #(.INIT(1'b1)) u_rst_pin (
    .clk(clk), .reset_n(reset_n), .din(chip_reset_in_n), .dout(rst_pin_s)
  );
  ebh_sync #(.INIT(1'b1)) u_rst_emu (
    .clk(clk), .reset_n(reset_n), .din(emulator_reset_n), .dout(rst_emu_s)
  );
  ebh_sync #(.INIT(1'b0)) u_ee (
    .clk(clk), .reset_n(reset_n), .din(emulator_enable), .dout(ee_s)
  );
  ebh_sync #(.INIT(1'b0)) u_step (
    .clk(clk), .reset_n(reset_n), .din(emu_single_step), .dout(step_s)
  );
  ebh_sync #(.INIT(1'b0)) u_halt (
    .clk(clk), .reset_n(reset_n), .din(emu_halted), .dout(halt_s)
  );

  assign ignore_s = ee_s & (step_s | halt_s);

  // pin selection; ignored inputs keep last value while stepping
  always_comb
  begin
    nxt_req = req_ff;
    nxt_rst = rst_ff;
    if (!ignore_s) // [RULE13]
    begin
      nxt_req = ~pick(ee_s, req_emu_s, req_pin_s); // [RULE10]
      nxt_rst = ~pick(ee_s, rst_emu_s, rst_pin_s); // [RULE10]
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_ff <= 1'b0;
      rst_ff <= 1'b0;
    end
    else
    begin
      req_ff <= nxt_req;
      rst_ff <= nxt_rst;
    end
  end

  // chip reset never blocks the handover, so requests work during it
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      EBH_OWN:
      begin
        if (req_ff) // [RULE7]
        begin
          if (ext_access_busy && !ext_access_done)
            nxt_state = EBH_WAIT_DONE; // [RULE4]
          else
            nxt_state = EBH_GRANTED; // [RULE2] [RULE5]
        end
      end
      EBH_WAIT_DONE:
      begin
        if (ext_access_done || !ext_access_busy)
          nxt_state = EBH_GRANTED; // [RULE4]
      end
      EBH_GRANTED:
      begin
        if (!req_ff)
          nxt_state = EBH_OWN; // [RULE6]
      end
      default:
        nxt_state = EBH_OWN;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_ff <= EBH_OWN;
    else
      state_ff <= nxt_state;
  end

  // grant and drivers move together on one edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      grant_ff <= 1'b0;
      drv_ff <= RST_DRV_EN;
    end
    else
    begin
      grant_ff <= (nxt_state == EBH_GRANTED); // [RULE2] [RULE6]
      drv_ff <= (nxt_state != EBH_GRANTED); // [RULE2] [RULE6]
    end
  end

  // hang: core wants to go but is blocked by a granted bus
  always_comb
  begin
    nxt_hang = 1'b0;
    if (nxt_state == EBH_GRANTED && core_ready)
      nxt_hang = go_mode ? core_ext_req : 1'b1; // [RULE8] [RULE3]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hang_ff <= 1'b0;
    else
      hang_ff <= nxt_hang; // [RULE9]
  end

  ebh_mode_latch u_mode (
    .clk(clk),
    .reset_n(reset_n),
    .chip_reset(rst_ff),
    .mode_pins(mode_pins),
    .mode(mem_mode)
  ); // [RULE12]

  assign bus_grant_n = ~(grant_ff & ~ee_s);
  assign bus_grant_oe = ~ee_s; // [RULE11]
  assign emulator_bus_grant_n = ~(grant_ff & ee_s); // [RULE10]
  assign grant_hang_n = ~hang_ff; // [RULE8]
  assign mem_drive_en = drv_ff; // [RULE14]
  // halted while granted, unless go mode and no external access
  assign core_run = ~grant_ff | (go_mode & ~core_ext_req); // [RULE3]
  assign ext_access_allow = ~grant_ff; // [RULE9]
  assign chip_reset = rst_ff;
endmodule : ebh_top
